// File: verilog/supply_cfg_consts.svh
// Purpose: Offsets, field positions, reset values and masks for the
//          driver supply configuration register.
// Assumes: One 32-bit register on APB.
// Notes:   Definitions only.
`ifndef SUPPLY_CFG_CONSTS_SVH
`define SUPPLY_CFG_CONSTS_SVH

`define DRIVER_SUPPLY_CONFIG_OFFSET 12'h000
`define ADDR_DECODE_WIDTH 12
`define PARITY_BIT 31
`define SEQ_DIS_BIT 24
`define CUR_LIM_BIT 23
`define VOUT_SEL_HI 22
`define VOUT_SEL_LO 21
`define MIN_ON_HI 19
`define MIN_ON_LO 17
`define SEQ_DIS_RESET 1'h1
`define CUR_LIM_RESET 1'h0
`define VOUT_SEL_RESET 2'h1
`define MIN_ON_RESET 3'h0
`define RESERVED_RESET 32'h0
`define DRIVER_SUPPLY_CONFIG_RESET 32'h01200000
`define PARITY_RESET 1'h0
`define RESERVED_BIT_RESET 1'h0
`define MIN_ON_AUTO_RESET 1'h0
`define RESERVED_MASK 32'h7E11FFFF
`define PRDATA_RESET 32'h00000000
`define READ_MISS_VALUE 32'h00000000

`endif

// File: verilog/supply_cfg_pkg.sv
// Purpose: Types for the driver supply configuration register.
// Assumes: Field codes as held in the register.
// Notes:   Offsets and reset values live in the consts header.
package supply_cfg_pkg;

  typedef enum logic [1:0] {
    VOUT_3V3,
    VOUT_5V0,
    VOUT_4V0,
    VOUT_5V7
  } vout_sel_t;

  typedef enum logic [2:0] {
    MIN_ON_ZERO,
    MIN_ON_AUTO,
    MIN_ON_0US50,
    MIN_ON_0US75,
    MIN_ON_1US00,
    MIN_ON_1US25,
    MIN_ON_1US50,
    MIN_ON_RSVD7
  } min_on_sel_t;

endpackage

// File: verilog/driver_supply_config_register.sv
// Purpose: One 32-bit APB register holding regulator and gate-driver
//          supply settings, with decoded field outputs.
// Assumes: APB3 slave, zero wait states, 125 MHz ref_clk.
// Notes:   Unmapped addresses read zero and raise pslverr.
`timescale 1ns/1ps
`include "supply_cfg_consts.svh"

module driver_supply_config_register (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Settings toward the regulator and gate driver
  output logic regulator_sequencing_disable,
  output logic regulator_current_limit_select,
  output supply_cfg_pkg::vout_sel_t vout_select,
  output supply_cfg_pkg::min_on_sel_t min_on_select,
  output logic min_on_auto
);
  import supply_cfg_pkg::*;

  // Bus phase decode and the write and read strobes.
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic rd_en;

  // Register state, one group per field of the word.
  logic seq_dis_q;
  logic seq_dis_d;
  logic cur_lim_q;
  logic cur_lim_d;
  vout_sel_t vout_q;
  vout_sel_t vout_d;
  min_on_sel_t min_on_q;
  min_on_sel_t min_on_d;
  logic min_on_auto_q;
  logic min_on_auto_d;
  logic parity_q;
  logic parity_d;
  wire [31:0] rsvd_word;
  logic [31:0] cfg_word;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Only the low address bits are decoded, so the register is seen at
  // every aliased address above them.
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[`ADDR_DECODE_WIDTH-1:0] == `DRIVER_SUPPLY_CONFIG_OFFSET);
  endfunction

  // A written one clears the bit; nothing in this block sets it again,
  // so software cannot re-disable sequencing short of a reset.
  function automatic logic w1c_next(
    input logic old_bit,
    input logic wr,
    input logic wbit
  );
    w1c_next = old_bit & ~(wr & wbit);
  endfunction

  // A plain read-write bit takes the written value.
  function automatic logic rw_next(
    input logic old_bit,
    input logic wr,
    input logic wbit
  );
    rw_next = wr ? wbit : old_bit;
  endfunction

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Writes land at the end of the access phase of a mapped address.
  assign wr_en = access_phase && pwrite && addr_hit(paddr);
  // Reads are captured at the end of setup so prdata comes from a flop.
  assign rd_en = setup_phase && !pwrite;

  always_comb begin
    seq_dis_d = w1c_next(seq_dis_q, wr_en, pwdata[`SEQ_DIS_BIT]);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_dis_q <= `SEQ_DIS_RESET;
    end else begin
      seq_dis_q <= seq_dis_d;
    end
  end

  always_comb begin
    cur_lim_d = rw_next(cur_lim_q, wr_en, pwdata[`CUR_LIM_BIT]);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_lim_q <= `CUR_LIM_RESET;
    end else begin
      cur_lim_q <= cur_lim_d;
    end
  end

  always_comb begin
    vout_d = vout_q;
    if (wr_en) begin
      vout_d = vout_sel_t'(pwdata[`VOUT_SEL_HI:`VOUT_SEL_LO]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vout_q <= vout_sel_t'(`VOUT_SEL_RESET);
    end else begin
      vout_q <= vout_d;
    end
  end

  always_comb begin
    min_on_d = min_on_q;
    if (wr_en) begin
      min_on_d = min_on_sel_t'(pwdata[`MIN_ON_HI:`MIN_ON_LO]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      min_on_q <= min_on_sel_t'(`MIN_ON_RESET);
    end else begin
      min_on_q <= min_on_d;
    end
  end

  // Code 1 hands the on-time to the slew-rate logic instead of a figure.
  always_comb begin
    min_on_auto_d = (min_on_d == MIN_ON_AUTO);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      min_on_auto_q <= `MIN_ON_AUTO_RESET;
    end else begin
      min_on_auto_q <= min_on_auto_d;
    end
  end

  always_comb begin
    parity_d = rw_next(parity_q, wr_en, pwdata[`PARITY_BIT]);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      parity_q <= `PARITY_RESET;
    end else begin
      parity_q <= parity_d;
    end
  end

  // Reserved bits only store what software writes; they feed nothing but
  // the read path, so no setting can depend on them.
  genvar gi;
  for (gi = 0; gi < 32; gi = gi + 1) begin : g_rsvd
    if (((`RESERVED_MASK >> gi) & 32'h1) != 32'h0) begin : g_store
      logic bit_q;
      logic bit_d;

      always_comb begin
        bit_d = rw_next(bit_q, wr_en, pwdata[gi]);
      end

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          bit_q <= `RESERVED_BIT_RESET;
        end else begin
          bit_q <= bit_d;
        end
      end

      assign rsvd_word[gi] = bit_q;
    end else begin : g_field
      assign rsvd_word[gi] = 1'b0;
    end
  end

  // The word as software reads it back.
  always_comb begin
    cfg_word = rsvd_word;
    cfg_word[`PARITY_BIT] = parity_q;
    cfg_word[`SEQ_DIS_BIT] = seq_dis_q;
    cfg_word[`CUR_LIM_BIT] = cur_lim_q;
    cfg_word[`VOUT_SEL_HI:`VOUT_SEL_LO] = vout_q;
    cfg_word[`MIN_ON_HI:`MIN_ON_LO] = min_on_q;
  end

  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = addr_hit(paddr) ? cfg_word : `READ_MISS_VALUE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `PRDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  // Zero wait states: every access phase completes at once.
  assign pready = 1'b1;
  // Unmapped offsets are refused in the access phase.
  assign pslverr = access_phase && !addr_hit(paddr);

  assign regulator_sequencing_disable = seq_dis_q;
  assign regulator_current_limit_select = cur_lim_q;
  assign vout_select = vout_q;
  assign min_on_select = min_on_q;
  assign min_on_auto = min_on_auto_q;

endmodule // driver_supply_config_register

// File: tb/cfg_checker.sv
// Purpose: port checker. Assumes: offset 0. Notes: bound below.
`timescale 1ns/1ps
module cfg_checker (
  input wire logic ref_clk, arst_n, psel, penable, pwrite,
  input wire logic [31:0] paddr, pwdata,
  input wire logic regulator_sequencing_disable, min_on_auto,
  input wire logic regulator_current_limit_select,
  input wire supply_cfg_pkg::vout_sel_t vout_select,
  input wire supply_cfg_pkg::min_on_sel_t min_on_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire wr = psel && penable && pwrite && paddr[11:0] == 12'h000;
  chk_flag_clear: assert property (wr && pwdata[24] |=>
    !regulator_sequencing_disable) else $error("flag kept");
  chk_limit_write: assert property (wr |=>
    regulator_current_limit_select == $past(pwdata[23])) else $error("lim");
  chk_vout_write: assert property (wr |=>
    vout_select == $past(pwdata[22:21])) else $error("vout");
  chk_min_on: assert property (wr |=>
    min_on_select == $past(pwdata[19:17]) &&
    min_on_auto == (min_on_select == 3'h1)) else $error("min on");
  sequence wr_access;
    psel && !penable && pwrite ##1 wr;
  endsequence
  chk_flag_keep: assert property (wr_access ##0 !pwdata[24] |=>
    regulator_sequencing_disable == $past(regulator_sequencing_disable))
    else $error("flag changed");
  chk_flag_no_set: assert property (!regulator_sequencing_disable |=>
    !regulator_sequencing_disable) else $error("flag set");
endmodule // cfg_checker
bind driver_supply_config_register cfg_checker chk (.*);

// File: tb/driver_supply_config_register_tb.sv
// Purpose: bench. Assumes: zero-wait APB. Notes: word model m.
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin \
  err_total++; $display("mismatch %0t %h %h",$time,a,b); end end
module driver_supply_config_register_tb;
  logic ref_clk=0, arst_n=0, psel=0, penable=0, pwrite=0, pready, er;
  logic s, c, u, e;
  logic [1:0] v;
  logic [2:0] o;
  logic [31:0] paddr=0, pwdata=0, prdata, rd, m=32'h01200000, d=0;
  logic [15:0] lf=16'hAC7A;
  int err_total=0, samples_checked=0;
  driver_supply_config_register dut (.ref_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(er),
    .regulator_sequencing_disable(s), .regulator_current_limit_select(c),
    .vout_select(v), .min_on_select(o), .min_on_auto(u));
  function logic [15:0] nx(logic [15:0] q);
    return {q[14:0], ^(q & 16'hB400)};
  endfunction
  task t(logic w, logic [31:0] a, x);
    @(posedge ref_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, x};
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    e = er;
    {psel, penable} <= 2'h0;
    if (w && !a[11:0]) m = {x[31:25], m[24] & ~x[24], x[23:0]};
  endtask
  task k;
    t(0, {d[19:0], 12'h000}, 0);
    `CHK({rd,e,s,c,v,o,u}, {m,1'h0,m[24:21],m[19:17],m[19:17]==3'h1})
  endtask
  task test_done;
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #99000 err_total++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1;
    k;
    t(1, 0, 0); k;
    repeat (40) begin
      lf = nx(lf); d = {lf, nx(lf)};
      t(1, 0, d); k;
      t(1, {d[31:12], 12'h004}, ~d);
      `CHK(e, 1'h1)
      k;
      t(0, 32'h8, 0); `CHK({e, rd}, 33'h100000000)
    end
    arst_n <= 0;
    @(posedge ref_clk) arst_n <= 1;
    m = 32'h01200000; k;
    test_done;
  end
endmodule // driver_supply_config_register_tb
